// [include/spq_map.svh]
// Behaviour
// - master phase 1 drives data at first edge
// - slave phase 1 starts on first clock edge
// - slave drives data out only when selected
// - no buffer load once a transfer began
// - master data write starts transfer, phase-independent
// - phase 0 clock idles first half-bit
// - master bit clock runs only when enabled
// - start latency at most one bit time
// - queued byte follows previous transfer at once
// - no new byte resends last shift value
// - idle: empty flag back within two cycles
// - busy slave loads buffer only after transfer
// - overflow at bit 1 strobe if unread
// - overflow blocks new bytes, keeps old one
// - status read then data read clears overflow
// - overflow shares error interrupt, no own enable
// - overflow blocks new full sets; receive irq holds while full
// - transfer end sets full and loads byte
// - write clears empty; status+data read clears full
`ifndef SPQ_MAP_SVH
`define SPQ_MAP_SVH
`define SPQ_STEP_ZERO    5'h00
`define SPQ_STEP_ONE     5'h01
`define SPQ_STEP_LAST    5'h10
`define SPQ_STEP_LAST_S1 5'h0F
`define SPQ_STEP_BIT1    5'h0D
`define SPQ_BYTE_ZERO    8'h00
`define SPQ_RATE_DIVIDE_BY_TWO    2'h0
`define SPQ_RATE_DIV8    2'h1
`define SPQ_RATE_DIVIDE_BY_THIRTY_TWO   2'h2
`define SPQ_HLAST_DIVIDE_BY_TWO   7'h00
`define SPQ_HLAST_DIV8   7'h03
`define SPQ_HLAST_DIVIDE_BY_THIRTY_TWO  7'h0F
`define SPQ_HLAST_DIVIDE_BY_ONE_TWENTY_EIGHT 7'h3F
`define SPQ_CNT_ZERO     7'h00
`define SPQ_CNT_ONE      7'h01
`endif

// [include/spq_pkg.sv]
package spq_pkg;
    typedef enum logic [1:0] {
        SPQ_IDLE  = 2'h0,
        SPQ_SHIFT = 2'h1,
        SPQ_END   = 2'h3
    } spq_state_t;
endpackage

// [include/spq_rx_if.sv]
`timescale 1ns/1ps
interface spq_rx_if;
    logic       done;
    logic [7:0] rx_byte;
    logic       ovr_check;
    logic       status_rd;
    logic       data_rd;
    logic       err_ie;
    logic       rx_ie;
    logic       full;
    logic       ovr;
    logic [7:0] rx_data;
    logic       irq;
    modport core  (output done, rx_byte, ovr_check, status_rd, data_rd, err_ie, rx_ie,
                   input full, ovr, rx_data, irq);
    modport flags (input done, rx_byte, ovr_check, status_rd, data_rd, err_ie, rx_ie,
                   output full, ovr, rx_data, irq);
endinterface

// [src/spq_baud.sv]
`timescale 1ns/1ps
`include "spq_map.svh"
module spq_baud (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [1:0] rate,
    output logic            half_tick
);
    logic [6:0] cnt_reg;
    logic       tick_reg;
    logic [6:0] last;

    always_comb begin
        if (rate == `SPQ_RATE_DIVIDE_BY_TWO) begin
            last = `SPQ_HLAST_DIVIDE_BY_TWO;
        end else if (rate == `SPQ_RATE_DIV8) begin
            last = `SPQ_HLAST_DIV8;
        end else if (rate == `SPQ_RATE_DIVIDE_BY_THIRTY_TWO) begin
            last = `SPQ_HLAST_DIVIDE_BY_THIRTY_TWO;
        end else begin
            last = `SPQ_HLAST_DIVIDE_BY_ONE_TWENTY_EIGHT;
        end
    end

    // free running: a write lands anywhere in the bit, hence the latency spread
    always_ff @(posedge core_clk) begin
        if (!rst_n || !run) begin
            cnt_reg  <= `SPQ_CNT_ZERO;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= (cnt_reg == last) ? `SPQ_CNT_ZERO : cnt_reg + `SPQ_CNT_ONE;
            tick_reg <= (cnt_reg == last);
        end
    end
    assign half_tick = tick_reg;

    property p_clk_idle;
        @(posedge core_clk) disable iff (!rst_n)
        !run |=> (cnt_reg == `SPQ_CNT_ZERO) && !half_tick;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("bit clock ran while stopped");
endmodule

// [src/spq_rxflags.sv]
`timescale 1ns/1ps
`include "spq_map.svh"
module spq_rxflags (
    input  wire logic core_clk,
    input  wire logic rst_n,
    spq_rx_if.flags   rxi
);
    logic       full_reg;
    logic       ovr_reg;
    logic       full_arm_reg;
    logic       ovr_arm_reg;
    logic       irq_reg;
    logic [7:0] data_reg;
    logic       set_full;
    logic       set_ovr;

    assign set_ovr  = rxi.ovr_check & full_reg;
    assign set_full = rxi.done & ~ovr_reg;

    // set wins over the read-sequence clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            full_reg <= 1'b0;
            ovr_reg  <= 1'b0;
        end else begin
            if (set_full) begin
                full_reg <= 1'b1;
            end else if (rxi.data_rd && full_arm_reg) begin
                full_reg <= 1'b0;
            end
            if (set_ovr) begin
                ovr_reg <= 1'b1;
            end else if (rxi.data_rd && ovr_arm_reg) begin
                ovr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            full_arm_reg <= 1'b0;
            ovr_arm_reg  <= 1'b0;
        end else if (rxi.status_rd) begin
            full_arm_reg <= full_reg;
            ovr_arm_reg  <= ovr_reg;
        end else if (rxi.data_rd) begin
            full_arm_reg <= 1'b0;
            ovr_arm_reg  <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            data_reg <= `SPQ_BYTE_ZERO;
        end else if (set_full) begin
            data_reg <= rxi.rx_byte;
        end
    end

    // one shared line; overflow has no enable of its own
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (rxi.rx_ie & full_reg) | (rxi.err_ie & ovr_reg);
        end
    end

    assign rxi.full    = full_reg;
    assign rxi.ovr     = ovr_reg;
    assign rxi.rx_data = data_reg;
    assign rxi.irq     = irq_reg;

    sequence s_ovr_read;
        rxi.status_rd && ovr_reg && !rxi.ovr_check ##1 rxi.data_rd && !rxi.ovr_check;
    endsequence
    property p_ovr_clear;
        @(posedge core_clk) disable iff (!rst_n) s_ovr_read |=> !ovr_reg;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overflow not cleared");

    property p_ovr_set;
        @(posedge core_clk) disable iff (!rst_n) rxi.ovr_check && full_reg |=> ovr_reg;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overflow missed");

    property p_ovr_hold;
        @(posedge core_clk) disable iff (!rst_n)
        ovr_reg && rxi.done |=> $stable(data_reg);
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("byte entered during overflow");

    property p_err_irq;
        @(posedge core_clk) disable iff (!rst_n) rxi.err_ie && ovr_reg |=> irq_reg;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("overflow raised no request");

    property p_no_full_ovr;
        @(posedge core_clk) disable iff (!rst_n)
        ovr_reg && rxi.done && !rxi.data_rd |=> $stable(full_reg);
    endproperty
    a_no_full_ovr: assert property (p_no_full_ovr) else $error("full set in overflow");

    property p_done_full;
        @(posedge core_clk) disable iff (!rst_n)
        rxi.done && !ovr_reg |=> full_reg && (data_reg == $past(rxi.rx_byte));
    endproperty
    a_done_full: assert property (p_done_full) else $error("end did not load byte");

    sequence s_full_read;
        rxi.status_rd && full_reg ##1 rxi.data_rd && !rxi.done;
    endsequence
    property p_full_clear;
        @(posedge core_clk) disable iff (!rst_n) s_full_read |=> !full_reg;
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("full not cleared");
endmodule

// [src/spq_top.sv]
`timescale 1ns/1ps
`include "spq_map.svh"
module spq_top (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       unit_enable,
    input  wire logic       master_select,
    input  wire logic       clock_phase,
    input  wire logic       clock_polarity,
    input  wire logic       rate_select_high,
    input  wire logic       rate_select_low,
    input  wire logic       error_interrupt_enable,
    input  wire logic       receive_interrupt_enable,
    input  wire logic       data_wr,
    input  wire logic [7:0] data_wdata,
    input  wire logic       data_rd,
    input  wire logic       status_rd,
    output logic      [7:0] data_rdata,
    output logic            transmit_empty_flag,
    output logic            receive_full_flag,
    output logic            overflow_flag,
    output logic            rx_err_irq,
    input  wire logic       serial_clock_pin_i,
    output logic            serial_clock_pin_o,
    output logic            serial_clock_pin_oe,
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe,
    input  wire logic       ss_n_i
);
    ////////////////////////////////////////////////////////////////////////////////
    spq_pkg::spq_state_t state_reg;
    logic [4:0]          step_reg;
    logic [7:0]          tx_sh_reg;
    logic [7:0]          rx_sh_reg;
    logic [7:0]          txbuf_reg;
    logic                txbuf_full_reg;
    logic                pend_reg;
    logic                te_reg;
    logic                sclk_reg;
    logic                sclk_prev_reg;
    logic                ss_prev_reg;
    logic                sclk_oe_reg;
    logic                mosi_oe_reg;
    logic                miso_oe_reg;
    logic                run;
    logic                half_tick;
    logic                s_sel;
    logic                sclk_edge;
    logic                m_start;
    logic                s_start;
    logic                edge_ev;
    logic                sample_ev;
    logic                shift_ev;
    logic                end_ev;
    logic                load_ev;
    logic                din;
    logic [4:0]          k;
    logic [4:0]          end_k;
    logic [7:0]          rx_next;

    spq_rx_if rxi ();

    assign run = unit_enable & master_select;

    spq_baud u_baud (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .run       (run),
        .rate      ({rate_select_high, rate_select_low}),
        .half_tick (half_tick)
    );

    spq_rxflags u_rxflags (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .rxi      (rxi)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // odd steps capture, even steps launch the next bit
    always_comb begin
        s_sel     = unit_enable & ~master_select & ~ss_n_i;
        sclk_edge = s_sel & (serial_clock_pin_i != sclk_prev_reg);
        m_start   = run & half_tick & pend_reg & (state_reg == spq_pkg::SPQ_IDLE);
        s_start   = (state_reg == spq_pkg::SPQ_IDLE) & s_sel &
                    (clock_phase ? sclk_edge : ss_prev_reg);
        edge_ev   = (state_reg == spq_pkg::SPQ_SHIFT) & (master_select ? half_tick : sclk_edge);
        k         = step_reg + `SPQ_STEP_ONE;
        // phase-1 slave sees only fifteen edges after the starting one
        end_k     = (!master_select && clock_phase) ? `SPQ_STEP_LAST_S1 : `SPQ_STEP_LAST;
        sample_ev = edge_ev & k[0];
        shift_ev  = edge_ev & ~k[0] & (k != `SPQ_STEP_LAST);
        end_ev    = edge_ev & (k == end_k);
        din       = master_select ? miso_i : mosi_i;
        rx_next   = sample_ev ? {rx_sh_reg[6:0], din} : rx_sh_reg;
        // a running transfer never takes the buffer; it waits for the end
        load_ev   = unit_enable & txbuf_full_reg & ~pend_reg &
                    (((state_reg == spq_pkg::SPQ_IDLE) & ~s_start) | end_ev);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slave deselect or disable abandons the transfer at once
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= spq_pkg::SPQ_IDLE;
            step_reg  <= `SPQ_STEP_ZERO;
        end else if (!unit_enable || (!master_select && ss_n_i)) begin
            state_reg <= spq_pkg::SPQ_IDLE;
            step_reg  <= `SPQ_STEP_ZERO;
        end else begin
            case (state_reg)
                spq_pkg::SPQ_IDLE: begin
                    if (m_start || s_start) begin
                        state_reg <= spq_pkg::SPQ_SHIFT;
                        step_reg  <= `SPQ_STEP_ZERO;
                    end
                end
                spq_pkg::SPQ_SHIFT: begin
                    if (end_ev) begin
                        state_reg <= spq_pkg::SPQ_END;
                    end else if (edge_ev) begin
                        step_reg <= k;
                    end
                end
                spq_pkg::SPQ_END: begin
                    state_reg <= spq_pkg::SPQ_IDLE;
                end
                default: begin
                    state_reg <= spq_pkg::SPQ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shift register: msb leaves first, pend marks a byte not yet sent
    always_ff @(posedge core_clk) begin
        if (!rst_n || !unit_enable) begin
            tx_sh_reg <= `SPQ_BYTE_ZERO;
            pend_reg  <= 1'b0;
        end else begin
            if (load_ev) begin
                tx_sh_reg <= txbuf_reg;
            end else if (end_ev) begin
                tx_sh_reg <= rx_next;
            end else if (shift_ev) begin
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
            if (load_ev) begin
                pend_reg <= 1'b1;
            end else if (m_start || s_start) begin
                pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_sh_reg <= `SPQ_BYTE_ZERO;
        end else if (sample_ev) begin
            rx_sh_reg <= rx_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // writes while disabled are dropped; the buffer flushes like the shifter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txbuf_reg      <= `SPQ_BYTE_ZERO;
            txbuf_full_reg <= 1'b0;
            te_reg         <= 1'b1;
        end else if (!unit_enable) begin
            txbuf_full_reg <= 1'b0;
            te_reg         <= 1'b1;
        end else begin
            if (data_wr) begin
                txbuf_reg <= data_wdata;
            end
            if (data_wr) begin
                txbuf_full_reg <= 1'b1;
                te_reg         <= 1'b0;
            end else if (load_ev) begin
                txbuf_full_reg <= 1'b0;
                te_reg         <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclk_reg <= 1'b0;
        end else if (!run) begin
            sclk_reg <= clock_polarity;
        end else if (m_start) begin
            sclk_reg <= clock_phase ? ~clock_polarity : clock_polarity;
        end else if (edge_ev && (!clock_phase || k != `SPQ_STEP_LAST)) begin
            sclk_reg <= ~sclk_reg;
        end else if (state_reg == spq_pkg::SPQ_IDLE) begin
            sclk_reg <= clock_polarity;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclk_prev_reg <= serial_clock_pin_i;
            ss_prev_reg   <= 1'b1;
        end else begin
            sclk_prev_reg <= serial_clock_pin_i;
            ss_prev_reg   <= ss_n_i;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclk_oe_reg <= 1'b0;
            mosi_oe_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else begin
            sclk_oe_reg <= run;
            mosi_oe_reg <= run;
            miso_oe_reg <= s_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign rxi.done      = end_ev;
    assign rxi.rx_byte   = rx_next;
    assign rxi.ovr_check = sample_ev & (k == `SPQ_STEP_BIT1);
    assign rxi.status_rd = status_rd;
    assign rxi.data_rd   = data_rd;
    assign rxi.err_ie    = error_interrupt_enable;
    assign rxi.rx_ie     = receive_interrupt_enable;

    assign data_rdata          = rxi.rx_data;
    assign receive_full_flag   = rxi.full;
    assign overflow_flag       = rxi.ovr;
    assign rx_err_irq          = rxi.irq;
    assign transmit_empty_flag = te_reg;
    assign serial_clock_pin_o  = sclk_reg;
    assign serial_clock_pin_oe = sclk_oe_reg;
    assign mosi_o              = tx_sh_reg[7];
    assign mosi_oe             = mosi_oe_reg;
    assign miso_o              = tx_sh_reg[7];
    assign miso_oe             = miso_oe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    property p_te_write;
        @(posedge core_clk) disable iff (!rst_n) data_wr && unit_enable |=> !te_reg;
    endproperty
    a_te_write: assert property (p_te_write) else $error("write left empty set");

    property p_te_reload;
        @(posedge core_clk) disable iff (!rst_n)
        unit_enable && !data_wr && txbuf_full_reg && !pend_reg &&
        state_reg == spq_pkg::SPQ_IDLE && !s_start |=> ##[0:1] te_reg;
    endproperty
    a_te_reload: assert property (p_te_reload) else $error("empty flag late");

    property p_latency;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(pend_reg) && run && state_reg == spq_pkg::SPQ_IDLE |->
        ##[1:130] state_reg == spq_pkg::SPQ_SHIFT || !run;
    endproperty
    a_latency: assert property (p_latency) else $error("start too late");

    property p_phase1_edge;
        @(posedge core_clk) disable iff (!rst_n)
        m_start && clock_phase |=> sclk_reg != clock_polarity;
    endproperty
    a_phase1_edge: assert property (p_phase1_edge) else $error("no first edge");

    property p_phase0_idle;
        @(posedge core_clk) disable iff (!rst_n)
        m_start && !clock_phase |=> sclk_reg == clock_polarity;
    endproperty
    a_phase0_idle: assert property (p_phase0_idle) else $error("clock left idle early");

    property p_miso_sel;
        @(posedge core_clk) disable iff (!rst_n) miso_oe |-> $past(!ss_n_i) && !$past(master_select);
    endproperty
    a_miso_sel: assert property (p_miso_sel) else $error("unselected slave drove");

    property p_busy_hold;
        @(posedge core_clk) disable iff (!rst_n)
        state_reg == spq_pkg::SPQ_SHIFT && !end_ev && unit_enable && data_wr |=> txbuf_full_reg;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("buffer moved mid transfer");

    property p_queue_next;
        @(posedge core_clk) disable iff (!rst_n)
        end_ev && txbuf_full_reg && !pend_reg && unit_enable |=> pend_reg;
    endproperty
    a_queue_next: assert property (p_queue_next) else $error("queued byte not taken");

    property p_resend;
        @(posedge core_clk) disable iff (!rst_n)
        end_ev && !txbuf_full_reg && unit_enable |=> tx_sh_reg == $past(rx_next);
    endproperty
    a_resend: assert property (p_resend) else $error("last value not kept");

    sequence s_fast_shift;
        state_reg == spq_pkg::SPQ_SHIFT && $past(state_reg) == spq_pkg::SPQ_IDLE &&
        run && !rate_select_high && !rate_select_low;
    endsequence
    property p_eight_bits;
        @(posedge core_clk) disable iff (!rst_n)
        s_fast_shift ##1 (run && !rate_select_high && !rate_select_low)[*8] |->
        ##8 state_reg == spq_pkg::SPQ_END;
    endproperty
    a_eight_bits: assert property (p_eight_bits) else $error("bit count wrong");
endmodule

// [bench/spq_peer.sv]
`timescale 1ns/1ps
module spq_peer (
    input  wire logic       serial_clock,
    input  wire logic       mosi,
    input  wire logic       phase,
    input  wire logic       sel_n,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic      [7:0] rx_byte,
    output int              rx_cnt
);
    logic [7:0] sh = 8'h00;
    logic [7:0] r  = 8'h00;
    int         k  = 0;
    // deselected: inverse level, so a stale bit never reads as data
    assign miso = sel_n ? ~sh[7] : sh[7];
    initial begin
        rx_cnt = 0;
        rx_byte = 8'h00;
    end
    always @(negedge sel_n) begin
        k = 0;
        sh = tx_byte;
    end
    always @(serial_clock) begin
        if (!sel_n) begin
            k = k + 1;
            if (k[0] ^ phase) begin
                r = {r[6:0], mosi};
            end else if (k != 1) begin
                sh = sh << 1;
            end
            if (k == 16) begin
                rx_byte = r;
                rx_cnt = rx_cnt + 1;
                k = 0;
                sh = tx_byte;
            end
        end
    end
endmodule

// [bench/tb_spq_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_spq_top;
    logic       core_clk  = 1'b0;
    logic       rst_n     = 1'b0;
    logic       unit_en   = 1'b0;
    logic       mst       = 1'b1;
    logic       phase     = 1'b0;
    logic       pol       = 1'b0;
    logic [1:0] rate      = 2'h0;
    logic       err_ie    = 1'b0;
    logic       data_wr   = 1'b0;
    logic [7:0] wdata     = 8'h00;
    logic       data_rd   = 1'b0;
    logic       status_rd = 1'b0;
    logic       ss_n      = 1'b1;
    logic       s_clk     = 1'b0;
    logic       s_mosi    = 1'b0;
    logic       rx_ie     = 1'b0;
    logic       sel_n     = 1'b1;
    logic [7:0] p_tx      = 8'h00;
    logic [7:0] rdata, p_rx, a, b, x;
    logic       tef, rff, ovf, irq, sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, s_miso;
    int         p_cnt, lat, bt, seed;
    int         errors    = 0;
    int         compares  = 0;
    int         cycles    = 0;

    always #5 core_clk = ~core_clk;

    spq_top i_spq_top (.core_clk(core_clk), .rst_n(rst_n), .unit_enable(unit_en),
        .master_select(mst), .clock_phase(phase), .clock_polarity(pol),
        .rate_select_high(rate[1]), .rate_select_low(rate[0]),
        .error_interrupt_enable(err_ie), .receive_interrupt_enable(rx_ie),
        .data_wr(data_wr), .data_wdata(wdata), .data_rd(data_rd), .status_rd(status_rd),
        .data_rdata(rdata), .transmit_empty_flag(tef), .receive_full_flag(rff),
        .overflow_flag(ovf), .rx_err_irq(irq), .serial_clock_pin_i(s_clk),
        .serial_clock_pin_o(sclk), .serial_clock_pin_oe(sclk_oe), .mosi_i(s_mosi),
        .mosi_o(mosi), .mosi_oe(mosi_oe), .miso_i(miso), .miso_o(s_miso),
        .miso_oe(miso_oe), .ss_n_i(ss_n));
    spq_peer i_spq_peer (.serial_clock(sclk), .mosi(mosi), .phase(phase), .sel_n(sel_n),
        .tx_byte(p_tx), .miso(miso), .rx_byte(p_rx), .rx_cnt(p_cnt));

    function automatic int bit_time(input logic [1:0] r);
        return 2 << (2 * r);
    endfunction
    task automatic tick(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic wait_cnt(input int t);
        int n;
        n = 0;
        while (p_cnt < t && n < 3000) begin
            tick();
            n++;
        end
    endtask
    // phase-1 master toward the slave; miso taken just before each capture edge
    task automatic slave_xfer(input logic [7:0] m, output logic [7:0] got);
        got = 8'h00;
        for (int e = 0; e < 16; e++) begin
            if (e[0]) begin
                got = {got[6:0], s_miso};
            end else begin
                s_mosi = m[7 - e / 2];
            end
            s_clk = ~s_clk;
            tick(4);
        end
    endtask
    // partner deselected while the format changes, so no stray edge counts
    task automatic setup(input logic ph, input logic pl, input logic [1:0] r);
        sel_n = 1'b1;
        unit_en = 1'b0;
        tick();
        phase = ph;
        pol = pl;
        rate = r;
        unit_en = 1'b1;
        tick(3);
        p_tx = 8'($urandom);
        x = p_tx;
        sel_n = 1'b0;
        tick();
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        seed = $urandom(47050);
        tick(12);
        rst_n = 1'b1;
        tick();
        `CHK("reset empty", 1'b1, tef)
        `CHK("reset clock oe", 1'b0, sclk_oe)
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            setup(c[0], c[1], c[3:2]);
            bt = bit_time(c[3:2]);
            a = 8'($urandom);
            wdata = a;
            pulse(data_wr);
            `CHK("empty clears", 1'b0, tef)
            tick();
            `CHK("empty back", 1'b1, tef)
            lat = 2;
            while (sclk === pol && lat < 400) begin
                tick();
                lat++;
            end
            `CHK("start delay", 1'b1, lat <= bt + (phase ? 0 : bt / 2) + 2)
            wait_cnt(p_cnt + 1);
            tick(bt / 2 + 3);
            `CHK("peer got", a, p_rx)
            `CHK("rx data", x, rdata)
            `CHK("full", 1'b1, rff)
            pulse(status_rd);
            pulse(data_rd);
            tick();
            `CHK("full clear", 1'b0, rff)
        end
        $display("test formats done");
        // queued pair, nothing read: second byte must overflow
        setup(1'b1, 1'b0, 2'h1);
        bt = bit_time(2'h1);
        err_ie = 1'b1;
        a = 8'($urandom);
        b = 8'($urandom);
        wdata = a;
        pulse(data_wr);
        tick();
        wdata = b;
        pulse(data_wr);
        p_tx = ~x;
        `CHK("queue held", 1'b0, tef)
        wait_cnt(p_cnt + 1);
        `CHK("first byte", a, p_rx)
        wait_cnt(p_cnt + 1);
        `CHK("queued byte", b, p_rx)
        tick(bt / 2 + 3);
        `CHK("overflow", 1'b1, ovf)
        `CHK("kept byte", x, rdata)
        `CHK("error irq", 1'b1, irq)
        pulse(status_rd);
        pulse(data_rd);
        tick(2);
        `CHK("ovf clear", 1'b0, ovf)
        `CHK("irq clear", 1'b0, irq)
        $display("test overflow done");
        sel_n = 1'b1;
        mst = 1'b0;
        rx_ie = 1'b1;
        wdata = a;
        pulse(data_wr);
        tick(3);
        `CHK("miso unselected", 1'b0, miso_oe)
        ss_n = 1'b0;
        tick(3);
        `CHK("miso selected", 1'b1, miso_oe)
        slave_xfer(b, x);
        tick(2);
        `CHK("slave sent", a, x)
        `CHK("slave got", b, rdata)
        `CHK("full irq", 1'b1, irq)
        ss_n = 1'b1;
        mst = 1'b1;
        tick(3);
        `CHK("clock on", 1'b1, sclk_oe)
        unit_en = 1'b0;
        tick(3);
        `CHK("clock off", 1'b0, sclk_oe)
        $display("test slave done");
        summarize();
    end
endmodule
